// ==== include/link_track_pkg.sv ====
// Purpose: Shared constants for the PHY connectivity tracking block.
// Assumes: 32-bit classic Wishbone register bus, word-aligned offsets.
// Notes: MDIO frame field positions refer to the observer shift register.
package link_track_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CONN_STATE = 8'h00;
	localparam logic [7:0] OFS_CHG_RAW = 8'h04;
	localparam logic [7:0] OFS_CHG_MASKED = 8'h08;
	localparam logic [7:0] OFS_CHG_ENABLE = 8'h0c;
	localparam logic [7:0] OFS_PHY_SEL_0 = 8'h10;
	localparam logic [7:0] OFS_PHY_SEL_1 = 8'h14;

	// Reset values
	localparam logic [31:0] RST_CONN_STATE = 32'h0000_0000;
	localparam logic [1:0] RST_CHG = 2'h0;
	localparam logic [1:0] RST_CHG_ENABLE = 2'h0;
	localparam logic [4:0] RST_PHY_SEL = 5'h00;

	// Generic status register address and its link-up bit
	localparam logic [4:0] GEN_STATUS_REG = 5'h01;
	localparam int LINK_UP_BIT = 2;

	// Observer frame layout: bits following the first start bit
	localparam int FRAME_BITS = 31;
	localparam int FB_START2 = 30;
	localparam int FB_OP_HI = 29;
	localparam int FB_OP_LO = 28;
	localparam int FB_PHY_HI = 27;
	localparam int FB_PHY_LO = 23;
	localparam int FB_REG_HI = 22;
	localparam int FB_REG_LO = 18;
	localparam int FB_TA_ACK = 16;
	localparam logic [1:0] OP_READ = 2'h2;

endpackage

// ==== include/status_rd_if.sv ====
// Purpose: Carries completed MDIO register reads from observer to tracker.
// Assumes: One core_clk domain; done is a one-cycle pulse.
// Notes: ack is high when the PHY drove the turnaround low.
`timescale 1ns/1ps
interface status_rd_if;
	logic done;
	logic [4:0] phy_addr;
	logic [4:0] reg_addr;
	logic ack;
	logic [15:0] data;

	modport src (output done, output phy_addr, output reg_addr,
		output ack, output data);
	modport dst (input done, input phy_addr, input reg_addr,
		input ack, input data);
endinterface

// ==== rtl/mdio_read_observer.sv ====
// Purpose: Watches MDC/MDIO pins and reports each completed read frame.
// Assumes: MDIO sampled on rising MDC; idle line is high (pull-up).
// Notes: Pins pass three flops; an MDC level counts once stages 2 and 3 agree, MDIO is taken from stage 3.
`timescale 1ns/1ps
module mdio_read_observer
	import link_track_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Serial pins
	input wire logic mdc_in,
	input wire logic mdio_in,
	// Read result
	status_rd_if.src rd
);

	logic [2:0] mdc_sync_q;
	logic [2:0] mdio_sync_q;
	logic mdc_lvl_q;
	logic mdc_rise;
	logic busy_q;
	logic [4:0] cnt_q;
	logic [FRAME_BITS-1:0] shift_q;
	logic [FRAME_BITS-1:0] shift_d;
	logic frame_end;

	// Three-stage synchronisers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mdc_sync_q <= 3'h7;
			mdio_sync_q <= 3'h7;
		end else begin
			mdc_sync_q <= {mdc_sync_q[1:0], mdc_in};
			mdio_sync_q <= {mdio_sync_q[1:0], mdio_in};
		end
	end

	// Filtered clock level, updated only when stages agree
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mdc_lvl_q <= 1'b1;
		end else if (mdc_sync_q[1] == mdc_sync_q[2]) begin
			mdc_lvl_q <= mdc_sync_q[2];
		end
	end

	assign mdc_rise = !mdc_lvl_q && mdc_sync_q[1] && mdc_sync_q[2];
	assign shift_d = {shift_q[FRAME_BITS-2:0], mdio_sync_q[2]};
	assign frame_end = busy_q && mdc_rise && (cnt_q == 5'(FRAME_BITS - 1));

	// Frame collector: a low bit on an idle line starts a frame
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 1'b0;
			cnt_q <= 5'h00;
			shift_q <= '0;
		end else if (mdc_rise) begin
			if (!busy_q) begin
				busy_q <= !mdio_sync_q[2];
				cnt_q <= 5'h00;
			end else begin
				shift_q <= shift_d;
				cnt_q <= cnt_q + 5'h01;
				busy_q <= !frame_end;
			end
		end
	end

	// Read result, registered; done pulses for read frames only
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd.done <= 1'b0;
			rd.phy_addr <= 5'h00;
			rd.reg_addr <= 5'h00;
			rd.ack <= 1'b0;
			rd.data <= 16'h0000;
		end else begin
			rd.done <= frame_end && shift_d[FB_START2] &&
				(shift_d[FB_OP_HI:FB_OP_LO] == OP_READ);
			if (frame_end) begin
				rd.phy_addr <= shift_d[FB_PHY_HI:FB_PHY_LO];
				rd.reg_addr <= shift_d[FB_REG_HI:FB_REG_LO];
				rd.ack <= !shift_d[FB_TA_ACK];
				rd.data <= shift_d[15:0];
			end
		end
	end

endmodule

// ==== rtl/phy_link_tracker.sv ====
// Purpose: Per-PHY connectivity vector and selected-PHY change events.
// Assumes: Classic Wishbone slave, 32-bit data, one-wait-state answer.
// Notes: Observer supplies read results; no interrupt output here.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module phy_link_tracker
	import link_track_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// MDIO pins, observed only
	input wire logic mdc_in,
	input wire logic mdio_in
);

	status_rd_if rd ();

	logic ack_q;
	logic [31:0] dat_q;
	logic [31:0] conn_q;
	logic [31:0] conn_d;
	logic [1:0] raw_q;
	logic [1:0] masked_q;
	logic [1:0] enable_q;
	logic [4:0] sel0_q;
	logic [4:0] sel1_q;
	logic [1:0] change;
	logic [1:0] clr;
	logic [1:0] clr_msk;
	logic req;
	logic wr;

	// Picks one PHY's bit out of the vector
	function automatic logic pick(input logic [31:0] vec,
		input logic [4:0] addr);
		pick = vec[addr];
	endfunction

	mdio_read_observer u_obs (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.mdc_in(mdc_in),
		.mdio_in(mdio_in),
		.rd(rd)
	);

	// Bus request decode
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Next connectivity vector from a generic status read
	always_comb begin
		conn_d = conn_q;
		if (rd.done && rd.reg_addr == GEN_STATUS_REG) begin
			conn_d[rd.phy_addr] = rd.ack && rd.data[LINK_UP_BIT];
		end
	end

	// Change detection for the two monitored addresses
	assign change[0] = pick(conn_d, sel0_q) != pick(conn_q, sel0_q);
	assign change[1] = pick(conn_d, sel1_q) != pick(conn_q, sel1_q);

	// Connectivity vector, no bus write path
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			conn_q <= RST_CONN_STATE;
		end else begin
			conn_q <= conn_d;
		end
	end

	// Raw and masked events, set wins over clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			raw_q <= RST_CHG;
			masked_q <= RST_CHG;
		end else begin
			raw_q <= (raw_q & ~clr) | change;
			masked_q <= (masked_q & ~clr_msk) |
				(change & enable_q);
		end
	end

	// Enable and select registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_q <= RST_CHG_ENABLE;
			sel0_q <= RST_PHY_SEL;
			sel1_q <= RST_PHY_SEL;
		end else if (wr) begin
			case (wb_adr_i)
				OFS_CHG_ENABLE: enable_q <= wb_dat_i[1:0];
				OFS_PHY_SEL_0: sel0_q <= wb_dat_i[4:0];
				OFS_PHY_SEL_1: sel1_q <= wb_dat_i[4:0];
				default: ;
			endcase
		end
	end

	// Write-one-to-clear masks; a zero bit leaves its event alone
	assign clr = (wr && wb_adr_i == OFS_CHG_RAW) ?
		wb_dat_i[1:0] : 2'h0;
	assign clr_msk = (wr && wb_adr_i == OFS_CHG_MASKED) ?
		wb_dat_i[1:0] : 2'h0;

	// Acknowledge one cycle after request, then drop
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Read data, unmapped reads return zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dat_q <= 32'h0000_0000;
		end else if (req) begin
			case (wb_adr_i)
				OFS_CONN_STATE: dat_q <= conn_q;
				OFS_CHG_RAW: dat_q <= {30'h0, raw_q};
				OFS_CHG_MASKED: dat_q <= {30'h0, masked_q};
				OFS_CHG_ENABLE: dat_q <= {30'h0, enable_q};
				OFS_PHY_SEL_0: dat_q <= {27'h0, sel0_q};
				OFS_PHY_SEL_1: dat_q <= {27'h0, sel1_q};
				default: dat_q <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// ==== testbench/link_track_properties.sv ====
// Purpose: Port-level checks for the PHY link tracker.
// Assumes: One core_clk domain; answer one edge after a request.
// Notes: Attached by bind; reads hold their address during ack.
`timescale 1ns/1ps
module link_track_props
	import link_track_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Serial pins
	input wire logic mdc_in,
	input wire logic mdio_in
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Request taken by the slave
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd(logic [7:0] a);
		wb_ack_o && !wb_we_i && wb_adr_i == a;
	endsequence
	// Bus timing
	property p_ack_next;
		s_take |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	// Only two event bits exist; unmapped reads return zero
	property p_raw_rsvd;
		s_rd(OFS_CHG_RAW) |-> wb_dat_o[31:2] == 30'h0;
	endproperty
	a_raw_rsvd: assert property (p_raw_rsvd) else $error("raw high");
	property p_msk_rsvd;
		s_rd(OFS_CHG_MASKED) |-> wb_dat_o[31:2] == 30'h0;
	endproperty
	a_msk_rsvd: assert property (p_msk_rsvd) else $error("msk high");
	property p_unmapped;
		s_rd(8'h18) |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule
bind phy_link_tracker link_track_props u_props (
	.core_clk(core_clk),
	.arst_n(arst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.mdc_in(mdc_in),
	.mdio_in(mdio_in)
);

// ==== testbench/phy_model.sv ====
// Purpose: PHY side of the serial link, sends whole read frames.
// Assumes: Clock idles low; line pulled up when released.
// Notes: One bit per 160 ns clock period.
`timescale 1ns/1ps
module phy_model (
	// Serial pins
	output logic mdc,
	output logic mdio
);
	initial mdc = 1'h0;
	initial mdio = 1'h1;
	// Preamble, header, turnaround, data; released line reads high
	task automatic frame(input logic [4:0] phy, input logic [4:0] rg,
		input logic ack, input logic [15:0] d);
		logic [63:0] f;
		f = {32'hffff_ffff, 4'h6, phy, rg, 1'h1, !ack, ack ? d : 16'hffff};
		for (int i = 63; i >= 0; i--) begin
			mdio <= f[i];
			#80 mdc <= 1'h1;
			#80 mdc <= 1'h0;
		end
		mdio <= 1'h1;
	endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the PHY link tracker.
// Assumes: Bus answers come after a taken request.
// Notes: Frames come from the PHY model.
`timescale 1ns/1ps
module tb_top
	import link_track_pkg::*;
;
	logic core_clk = 1'h0;
	logic arst_n = 1'h0;
	logic wb_cyc_i = 1'h0;
	logic wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic mdc;
	logic mdio;
	int error_cnt = 0;
	int n_compared = 0;
	// Core clock, 50 MHz
	always #10 core_clk = ~core_clk;
	phy_link_tracker u_dut (.core_clk(core_clk), .arst_n(arst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mdc_in(mdc),
		.mdio_in(mdio));
	phy_model u_phy (.mdc(mdc), .mdio(mdio));
	// One bus cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge core_clk); while (wb_ack_o !== 1'h1);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, r);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'h0, a, 32'h0, r);
		n_compared++;
		if (r !== e) begin
			error_cnt++;
			$display("Error reg %h exp %h got %h", a, e, r);
		end
	endtask
	task automatic frm(input logic [4:0] p, input logic [4:0] g,
		input logic k, input logic [15:0] d);
		u_phy.frame(p, g, k, d);
		repeat (8) @(posedge core_clk);
	endtask
	task automatic t_reset();
		chk(OFS_CONN_STATE, 32'h0);
		chk(OFS_CHG_RAW, 32'h0);
		chk(OFS_CHG_MASKED, 32'h0);
		chk(8'h18, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_up();
		wr(OFS_PHY_SEL_0, 32'h3);
		wr(OFS_PHY_SEL_1, 32'h5);
		wr(OFS_CHG_ENABLE, 32'h1);
		frm(5'h03, GEN_STATUS_REG, 1'h1, 16'h0004);
		chk(OFS_CONN_STATE, 32'h8);
		chk(OFS_CHG_RAW, 32'h1);
		chk(OFS_CHG_MASKED, 32'h1);
		frm(5'h05, 5'h02, 1'h1, 16'h0004);
		chk(OFS_CONN_STATE, 32'h8);
		frm(5'h05, GEN_STATUS_REG, 1'h1, 16'h0004);
		chk(OFS_CONN_STATE, 32'h28);
		chk(OFS_CHG_RAW, 32'h3);
		chk(OFS_CHG_MASKED, 32'h1);
		$display("link up test done");
	endtask
	task automatic t_clear();
		wr(OFS_CHG_RAW, 32'h0);
		chk(OFS_CHG_RAW, 32'h3);
		wr(OFS_CHG_RAW, 32'h1);
		chk(OFS_CHG_RAW, 32'h2);
		// Without byte 0 enabled the clear is ignored
		wb_sel_i <= 4'he;
		wr(OFS_CHG_RAW, 32'h2);
		wb_sel_i <= 4'hf;
		chk(OFS_CHG_RAW, 32'h2);
		wr(OFS_CHG_MASKED, 32'h1);
		chk(OFS_CHG_MASKED, 32'h0);
		wr(OFS_CONN_STATE, 32'hffff_ffff);
		chk(OFS_CONN_STATE, 32'h28);
		$display("clear test done");
	endtask
	task automatic t_down();
		frm(5'h03, GEN_STATUS_REG, 1'h1, 16'hfffb);
		chk(OFS_CONN_STATE, 32'h20);
		chk(OFS_CHG_RAW, 32'h3);
		chk(OFS_CHG_MASKED, 32'h1);
		frm(5'h05, GEN_STATUS_REG, 1'h0, 16'h0004);
		chk(OFS_CONN_STATE, 32'h0);
		$display("link down test done");
	endtask
	// Event and its clear land on one edge: the event must stay
	task automatic t_race();
		wr(OFS_CHG_RAW, 32'h3);
		wr(OFS_CHG_MASKED, 32'h3);
		chk(OFS_CHG_RAW, 32'h0);
		fork
			u_phy.frame(5'h03, GEN_STATUS_REG, 1'h1, 16'h0004);
			begin
				// Last MDC rise at 508 cycles, set lands 5 later
				repeat (511) @(posedge core_clk);
				wr(OFS_CHG_RAW, 32'h1);
			end
		join
		repeat (8) @(posedge core_clk);
		chk(OFS_CONN_STATE, 32'h8);
		chk(OFS_CHG_RAW, 32'h1);
		chk(OFS_CHG_MASKED, 32'h1);
		$display("race test done");
	endtask
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Reset, then the tests in order
	initial begin
		repeat (12) @(posedge core_clk);
		arst_n <= 1'h1;
		t_reset();
		t_up();
		t_clear();
		t_down();
		t_race();
		summarize();
	end
	// Watchdog against a hung bus or frame
	initial begin
		#200us;
		error_cnt++;
		summarize();
	end
endmodule
